// >>> bmc_params.svh
`ifndef BMC_PARAMS_SVH
`define BMC_PARAMS_SVH

// ----------------------------------------------------------------------
// management access
// ----------------------------------------------------------------------
`define BMC_ADDR_W        5
`define BMC_DATA_W        16
`define BMC_REG_ADDR      5'h00
`define BMC_ZERO_WORD     16'h0000

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BMC_B_RESET       15
`define BMC_B_LOOP        14
`define BMC_B_SPEED       13
`define BMC_B_AN_EN       12
`define BMC_B_PWR_DN      11
`define BMC_B_ISOLATE     10
`define BMC_B_RESTART     9
`define BMC_B_DUPLEX      8
`define BMC_B_COLL        7
`define BMC_RSVD_HI       6
`define BMC_RSVD_LO       0
`define BMC_RSVD_VAL      7'h00

// ----------------------------------------------------------------------
// defaults
// ----------------------------------------------------------------------
`define BMC_DEF_RESET     1'b0
`define BMC_DEF_LOOP      1'b0
`define BMC_DEF_SPEED     1'b1
`define BMC_DEF_AN_EN     1'b1
`define BMC_DEF_PWR_DN    1'b0
`define BMC_DEF_ISOLATE   1'b0
`define BMC_DEF_RESTART   1'b0
`define BMC_DEF_DUPLEX    1'b1
`define BMC_DEF_COLL      1'b0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define BMC_CLK_PERIOD_NS 5
`define BMC_SWRST_NS      1000
`define BMC_DEAD_MS       720
`define BMC_NS_PER_MS     1000000
`define BMC_SWRST_CYCLES  ((`BMC_SWRST_NS + `BMC_CLK_PERIOD_NS - 1) \
                           / `BMC_CLK_PERIOD_NS)
`define BMC_DEAD_CYCLES   ((`BMC_DEAD_MS * `BMC_NS_PER_MS) / `BMC_CLK_PERIOD_NS)
// the reset and dead-time checks watch eight cycles of each window
`define BMC_MIN_CYCLES    8

`endif

// >>> bmc_pkg.sv
`default_nettype none
`include "bmc_params.svh"

package bmc_pkg;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    BMC_RUN   = 1'b0,
    BMC_SWRST = 1'b1
  } bmc_mode_e;

  typedef struct packed {
    bmc_mode_e                mode;
    logic                     loopback;
    logic                     loop_d;
    logic                     speed;
    logic                     an_en;
    logic                     pwr_dn;
    logic                     isolate;
    logic                     restart;
    logic                     duplex;
    logic                     coll_test;
    logic [`BMC_DATA_W-1:0]   rdata;
    logic                     rvalid;
  } bmc_state_s;

endpackage : bmc_pkg

`default_nettype wire

// >>> bmc_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none

interface bmc_tmr_if;
  logic start;
  logic busy;
  modport ctrl (output start, input busy);
  modport tmr  (input start, output busy);
endinterface : bmc_tmr_if

`default_nettype wire

// >>> bmc_timer.sv
`timescale 1ns/1ps
`default_nettype none

module bmc_timer #(
  parameter int unsigned CYCLES = 200
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // control
  bmc_tmr_if.tmr    tif
);

  localparam int unsigned W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
  } bmc_tmr_s;

  bmc_tmr_s st_r;
  bmc_tmr_s st_nxt;

  if (CYCLES < 1) begin : g_chk
    $error("bmc_timer: CYCLES must be at least one");
  end

  // a new start reloads, so a later event extends the busy window
  always_comb begin
    st_nxt = st_r;
    if (tif.start) begin
      st_nxt.cnt = CYCLES[W-1:0];
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tif.busy = (st_r.cnt != '0);

  tmr_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    tif.start |=> (st_r.cnt == CYCLES[W-1:0]) && tif.busy)
    else $error("timer did not load on start");

endmodule : bmc_timer

`default_nettype wire

// >>> bmc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "bmc_params.svh"

// ----------------------------------------------------------------------
// basic mode control register
// ----------------------------------------------------------------------

module bmc_ctrl #(
  parameter int unsigned SWRST_CYCLES = `BMC_SWRST_CYCLES,
  parameter int unsigned DEAD_CYCLES  = `BMC_DEAD_CYCLES
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  // management access
  input  wire logic                   mgmt_wr_en,
  input  wire logic                   mgmt_rd_en,
  input  wire logic [`BMC_ADDR_W-1:0] mgmt_addr,
  input  wire logic [`BMC_DATA_W-1:0] mgmt_wdata,
  output logic      [`BMC_DATA_W-1:0] mgmt_rdata,
  output logic                        mgmt_rdata_valid,
  // negotiation and line status
  input  wire logic                   an_speed_100,
  input  wire logic                   an_full_duplex,
  input  wire logic                   an_started,
  input  wire logic                   tx_active,
  // control outputs
  output logic                        phy_reset,
  output logic                        loopback_en,
  output logic                        speed_100,
  output logic                        full_duplex,
  output logic                        an_enable,
  output logic                        an_restart_req,
  output logic                        power_down,
  output logic                        isolate,
  output logic                        collision_force,
  output logic                        rx_dead
);

  bmc_pkg::bmc_state_s st_r;
  bmc_pkg::bmc_state_s st_nxt;
  logic                wr0;
  logic                rd0;
  logic                swrst_start;
  logic                dead_start;

  bmc_tmr_if tif_rst ();
  bmc_tmr_if tif_dead ();

  if (SWRST_CYCLES < `BMC_MIN_CYCLES ||
      DEAD_CYCLES < `BMC_MIN_CYCLES) begin : g_chk
    $error("bmc_ctrl: timer counts too small for the window checks");
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic bmc_pkg::bmc_state_s bmc_defaults(
    input bmc_pkg::bmc_state_s s
  );
    bmc_pkg::bmc_state_s d;
    d           = s;
    d.loopback  = `BMC_DEF_LOOP;
    d.speed     = `BMC_DEF_SPEED;
    d.an_en     = `BMC_DEF_AN_EN;
    d.pwr_dn    = `BMC_DEF_PWR_DN;
    d.isolate   = `BMC_DEF_ISOLATE;
    d.restart   = `BMC_DEF_RESTART;
    d.duplex    = `BMC_DEF_DUPLEX;
    d.coll_test = `BMC_DEF_COLL;
    return d;
  endfunction : bmc_defaults

  function automatic logic [`BMC_DATA_W-1:0] bmc_word(
    input bmc_pkg::bmc_state_s s,
    input logic                spd,
    input logic                dup
  );
    logic [`BMC_DATA_W-1:0] w;
    w                             = `BMC_ZERO_WORD;
    w[`BMC_B_RESET]               = (s.mode == bmc_pkg::BMC_SWRST);
    w[`BMC_B_LOOP]                = s.loopback;
    w[`BMC_B_SPEED]               = s.an_en ? spd : s.speed;
    w[`BMC_B_AN_EN]               = s.an_en;
    w[`BMC_B_PWR_DN]              = s.pwr_dn;
    w[`BMC_B_ISOLATE]             = s.isolate;
    w[`BMC_B_RESTART]             = s.restart;
    w[`BMC_B_DUPLEX]              = s.an_en ? dup : s.duplex;
    w[`BMC_B_COLL]                = s.coll_test;
    w[`BMC_RSVD_HI:`BMC_RSVD_LO]  = `BMC_RSVD_VAL;
    return w;
  endfunction : bmc_word

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  assign wr0 = mgmt_wr_en && (mgmt_addr == `BMC_REG_ADDR);
  assign rd0 = mgmt_rd_en && (mgmt_addr == `BMC_REG_ADDR);

  always_comb begin
    st_nxt        = st_r;
    swrst_start   = 1'b0;
    st_nxt.rvalid = 1'b0;
    st_nxt.loop_d = st_r.loopback;
    // reads are served in every mode, power-down included
    if (mgmt_rd_en) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd0 ? bmc_word(st_r, an_speed_100, an_full_duplex)
                          : `BMC_ZERO_WORD;
    end
    case (st_r.mode)
      bmc_pkg::BMC_RUN: begin
        if (an_started) begin
          st_nxt.restart = 1'b0;
        end
        if (wr0 && mgmt_wdata[`BMC_B_RESET]) begin
          swrst_start = 1'b1;
          st_nxt      = bmc_defaults(st_nxt);
          st_nxt.mode = bmc_pkg::BMC_SWRST;
        end else if (wr0) begin
          st_nxt.loopback  = mgmt_wdata[`BMC_B_LOOP];
          st_nxt.speed     = mgmt_wdata[`BMC_B_SPEED];
          st_nxt.an_en     = mgmt_wdata[`BMC_B_AN_EN];
          st_nxt.pwr_dn    = mgmt_wdata[`BMC_B_PWR_DN];
          st_nxt.isolate   = mgmt_wdata[`BMC_B_ISOLATE];
          st_nxt.duplex    = mgmt_wdata[`BMC_B_DUPLEX];
          st_nxt.coll_test = mgmt_wdata[`BMC_B_COLL];
          // a write of one beats a same-cycle start; a write of zero
          // only drops the flag, negotiation already begun runs on
          st_nxt.restart   = mgmt_wdata[`BMC_B_RESTART]
                             & mgmt_wdata[`BMC_B_AN_EN];
        end
      end
      bmc_pkg::BMC_SWRST: begin
        // writes are dropped while the reset runs
        st_nxt = bmc_defaults(st_nxt);
        if (!tif_rst.busy) begin
          st_nxt.mode = bmc_pkg::BMC_RUN;
        end
      end
      default: begin
        st_nxt.mode = bmc_pkg::BMC_RUN;
      end
    endcase
  end

  // the rising edge of loopback is taken from the registered copy, so the
  // speed seen is the one in force once loopback is actually on
  assign dead_start = st_r.loopback & ~st_r.loop_d & speed_100;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_r        <= bmc_defaults('0);
      st_r.mode   <= bmc_pkg::BMC_RUN;
      st_r.rdata  <= `BMC_ZERO_WORD;
      st_r.rvalid <= 1'b0;
      st_r.loop_d <= `BMC_DEF_LOOP;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------------
  assign tif_rst.start  = swrst_start;
  assign tif_dead.start = dead_start;

  bmc_timer #(.CYCLES(SWRST_CYCLES)) u_rst_tmr (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tif     (tif_rst)
  );

  bmc_timer #(.CYCLES(DEAD_CYCLES)) u_dead_tmr (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tif     (tif_dead)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign mgmt_rdata       = st_r.rdata;
  assign mgmt_rdata_valid = st_r.rvalid;
  assign phy_reset        = (st_r.mode == bmc_pkg::BMC_SWRST);
  assign loopback_en      = st_r.loopback;
  assign speed_100        = st_r.an_en ? an_speed_100 : st_r.speed;
  assign full_duplex      = st_r.an_en ? an_full_duplex
                                       : st_r.duplex;
  assign an_enable        = st_r.an_en;
  assign an_restart_req   = st_r.restart & st_r.an_en;
  assign power_down       = st_r.pwr_dn;
  // isolate is passed on as written; software is expected to keep it low
  assign isolate          = st_r.isolate;
  assign collision_force  = st_r.coll_test & tx_active;
  assign rx_dead          = tif_dead.busy;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_swrst_write;
    wr0 && mgmt_wdata[`BMC_B_RESET] && !phy_reset;
  endsequence

  sequence s_swrst_hold;
    phy_reset [*8];
  endsequence

  swrst_self_clear_a: assert property (
    s_swrst_write |=> s_swrst_hold ##[0:SWRST_CYCLES] !phy_reset)
    else $error("software reset did not hold then clear");

  swrst_defaults_a: assert property (
    $rose(phy_reset) |-> !loopback_en && an_enable && !power_down
      && !isolate && !an_restart_req && st_r.speed && st_r.duplex
      && !st_r.coll_test)
    else $error("software reset left a field off its default");

  loopback_write_a: assert property (
    wr0 && !phy_reset && !mgmt_wdata[`BMC_B_RESET]
      |=> loopback_en == $past(mgmt_wdata[`BMC_B_LOOP]))
    else $error("loopback did not follow the write");

  dead_time_a: assert property (
    $rose(loopback_en) && speed_100 |=> rx_dead [*8])
    else $error("no dead period after loopback at 100 Mbps");

  speed_manual_a: assert property (
    !an_enable |-> speed_100 == st_r.speed && full_duplex == st_r.duplex)
    else $error("manual speed or duplex not applied");

  read_status_a: assert property (
    rd0 && an_enable |=> mgmt_rdata_valid
      && mgmt_rdata[`BMC_B_SPEED] == $past(an_speed_100)
      && mgmt_rdata[`BMC_B_DUPLEX] == $past(an_full_duplex))
    else $error("read did not show negotiated speed and duplex");

  pd_answers_a: assert property (
    power_down && mgmt_rd_en |=> mgmt_rdata_valid)
    else $error("no answer while powered down");

  restart_clear_a: assert property (
    an_restart_req && an_started && !wr0 && !phy_reset |=> !an_restart_req)
    else $error("restart bit did not clear after start");

  restart_ignored_a: assert property (
    wr0 && !mgmt_wdata[`BMC_B_RESET] && !mgmt_wdata[`BMC_B_AN_EN]
      && !phy_reset |=> !st_r.restart)
    else $error("restart took effect with negotiation off");

  coll_force_a: assert property (
    collision_force |-> tx_active && st_r.coll_test)
    else $error("collision forced without test bit or transmit");

  rsvd_zero_a: assert property (
    mgmt_rdata_valid |-> mgmt_rdata[`BMC_RSVD_HI:`BMC_RSVD_LO]
      == `BMC_RSVD_VAL)
    else $error("reserved bits read nonzero");

endmodule : bmc_ctrl

`default_nettype wire

// >>> bmc_mgmt_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "bmc_params.svh"

// ----------------------------------------------------------------------
// management entity: one strobe per access, bus scrambled when idle
// ----------------------------------------------------------------------
module bmc_mgmt_model (
  // clock
  input  wire logic                   ref_clk,
  // management bus
  output logic                        mgmt_wr_en,
  output logic                        mgmt_rd_en,
  output logic      [`BMC_ADDR_W-1:0] mgmt_addr,
  output logic      [`BMC_DATA_W-1:0] mgmt_wdata,
  input  wire logic [`BMC_DATA_W-1:0] mgmt_rdata,
  input  wire logic                   mgmt_rdata_valid
);
  initial begin
    mgmt_wr_en = 1'b0;
    mgmt_rd_en = 1'b0;
    mgmt_addr  = 5'h1F;
    mgmt_wdata = 16'hA5A5;
  end

  // raw skips the usage limits, for refusal scenarios only
  task automatic wr(input logic [4:0] a, input logic [15:0] d,
                    input bit raw, output logic [15:0] v);
    v = d;
    if (!raw && a == 5'h00) begin
      v[10] = 1'b0;
      if (!v[12]) v[9] = 1'b0;
    end
    @(posedge ref_clk);
    #1;
    mgmt_addr  = a;
    mgmt_wdata = v;
    mgmt_wr_en = 1'b1;
    @(posedge ref_clk);
    #1;
    mgmt_wr_en = 1'b0;
    mgmt_addr  = ~a;
    mgmt_wdata = ~v;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] q,
                    output logic ok);
    @(posedge ref_clk);
    #1;
    mgmt_addr  = a;
    mgmt_rd_en = 1'b1;
    @(posedge ref_clk);
    #1;
    mgmt_rd_en = 1'b0;
    mgmt_addr  = ~a;
    ok = mgmt_rdata_valid;
    q  = mgmt_rdata;
  endtask : rd
endmodule : bmc_mgmt_model

`default_nettype wire

// >>> test_phy_basic_mode_control.sv
`timescale 1ns/1ps
`default_nettype none

module test_phy_basic_mode_control;
  logic        ref_clk, resetn, wr_en, rd_en, valid;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata;
  logic        an_speed_100, an_full_duplex, an_started, tx_active;
  logic        phy_reset, loopback_en, speed_100, full_duplex, an_enable;
  logic        an_restart_req, power_down, isolate, collision_force;
  logic        rx_dead;
  logic [15:0] m_ctl;
  logic        m_rst;
  int          n_errors, checks, cyc, c0, i;
  int          seed = 32'hca4f478c;
  logic [31:0] r;

  bmc_ctrl #(.SWRST_CYCLES(8), .DEAD_CYCLES(16)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .mgmt_wr_en(wr_en),
    .mgmt_rd_en(rd_en), .mgmt_addr(addr), .mgmt_wdata(wdata),
    .mgmt_rdata(rdata), .mgmt_rdata_valid(valid),
    .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex),
    .an_started(an_started), .tx_active(tx_active),
    .phy_reset(phy_reset), .loopback_en(loopback_en),
    .speed_100(speed_100), .full_duplex(full_duplex),
    .an_enable(an_enable), .an_restart_req(an_restart_req),
    .power_down(power_down), .isolate(isolate),
    .collision_force(collision_force), .rx_dead(rx_dead));

  bmc_mgmt_model i_mgmt (
    .ref_clk(ref_clk), .mgmt_wr_en(wr_en), .mgmt_rd_en(rd_en),
    .mgmt_addr(addr), .mgmt_wdata(wdata), .mgmt_rdata(rdata),
    .mgmt_rdata_valid(valid));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic chk_out();
    logic [7:0] e;
    e = {m_rst, m_ctl[14], m_ctl[12] ? an_speed_100 : m_ctl[13],
         m_ctl[12], m_ctl[11], m_ctl[10], m_ctl[9],
         m_ctl[12] ? an_full_duplex : m_ctl[8]};
    chk("outputs", {8'h00, phy_reset, loopback_en, speed_100, an_enable,
        power_down, isolate, an_restart_req, full_duplex}, {8'h00, e});
    chk("coll", {15'h0, collision_force},
        {15'h0, m_ctl[7] & tx_active});
  endtask : chk_out

  // model follows the value the partner really sent
  task automatic wrc(input logic [4:0] a, input logic [15:0] d, input bit raw);
    logic [15:0] v;
    i_mgmt.wr(a, d, raw, v);
    if (a == 5'h00 && !m_rst) begin
      if (v[15]) begin
        m_ctl = 16'h3100;
        m_rst = 1'b1;
      end else begin
        m_ctl = {1'b0, v[14:10], v[9] & v[12], v[8:7], 7'h00};
      end
    end
    chk_out();
  endtask : wrc

  task automatic rdc(input logic [4:0] a);
    logic [15:0] q, e;
    logic        ok;
    e = m_ctl;
    e[15] = m_rst;
    if (e[12]) begin
      e[13] = an_speed_100;
      e[8]  = an_full_duplex;
    end
    if (a != 5'h00) e = 16'h0000;
    i_mgmt.rd(a, q, ok);
    chk("valid", {15'h0, ok}, 16'h0001);
    chk("rdata", q, e);
  endtask : rdc

  initial begin
    resetn = 1'b0;
    an_speed_100 = 1'b1;
    an_full_duplex = 1'b0;
    an_started = 1'b0;
    tx_active = 1'b0;
    m_ctl = 16'h3100;
    m_rst = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    rdc(5'h00);
    chk_out();
    // ------------------------------------------------------------------
    // random fields, an status and unmapped addresses
    // ------------------------------------------------------------------
    for (i = 0; i < 30; i++) begin
      r = $random(seed);
      {an_speed_100, an_full_duplex, tx_active} = r[7:5];
      wrc((i % 6 == 5) ? (r[4:0] | 5'h01) : 5'h00, {1'b0, r[30:16]}, 1'b0);
      rdc(5'h00);
      rdc(r[12:8]);
    end
    // ------------------------------------------------------------------
    // restart: refused when manual, cleared by write or by start
    // ------------------------------------------------------------------
    wrc(5'h00, 16'h0200, 1'b1);
    rdc(5'h00);
    wrc(5'h00, 16'h1200, 1'b0);
    rdc(5'h00);
    wrc(5'h00, 16'h1000, 1'b0);
    wrc(5'h00, 16'h1200, 1'b0);
    an_started = 1'b1;
    @(posedge ref_clk);
    #1;
    an_started = 1'b0;
    m_ctl[9] = 1'b0;
    @(posedge ref_clk);
    #1;
    chk_out();
    rdc(5'h00);
    // ------------------------------------------------------------------
    // loopback dead time at 100 and none at 10
    // ------------------------------------------------------------------
    an_speed_100 = 1'b1;
    wrc(5'h00, 16'h7100, 1'b0);
    @(posedge ref_clk);
    #1;
    chk("dead", {15'h0, rx_dead}, 16'h0001);
    repeat (20) @(posedge ref_clk);
    #1;
    chk("dead", {15'h0, rx_dead}, 16'h0000);
    wrc(5'h00, 16'h0100, 1'b0);
    wrc(5'h00, 16'h4100, 1'b0);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("dead", {15'h0, rx_dead}, 16'h0000);
    // ------------------------------------------------------------------
    // software reset: defaults, writes dropped, self clear
    // ------------------------------------------------------------------
    wrc(5'h00, 16'h4D80, 1'b0);
    wrc(5'h00, 16'hC880, 1'b0);
    c0 = cyc;
    rdc(5'h00);
    wrc(5'h00, 16'h4080, 1'b0);
    while (phy_reset === 1'b1 && cyc < c0 + 40) begin
      @(posedge ref_clk);
      #1;
    end
    m_rst = 1'b0;
    chk("swrst_len", 16'(cyc - c0), 16'h0009);
    chk_out();
    rdc(5'h00);
    test_done();
  end
endmodule : test_phy_basic_mode_control

`default_nettype wire
